/* File: hw/swe_pkg.sv */
// Shared constants for the single-wire EEPROM read and zone-protection core
package swe_pkg;

	// ------------------------------------------------------------------
	// Device address byte opcodes (upper nibble)
	// ------------------------------------------------------------------
	localparam logic [3:0] OP_MAIN = 4'ha;
	localparam logic [3:0] OP_EXT = 4'hb;
	localparam logic [3:0] OP_IDENT = 4'hc;
	localparam logic [3:0] OP_ZONE = 4'h7;

	// ------------------------------------------------------------------
	// Device address byte fields
	// ------------------------------------------------------------------
	localparam int DEV_OP_MSB = 7;
	localparam int DEV_OP_LSB = 4;
	localparam int DEV_SLV_MSB = 3;
	localparam int DEV_SLV_LSB = 1;
	localparam int DEV_RW_BIT = 0;

	// ------------------------------------------------------------------
	// Memory geometry
	// ------------------------------------------------------------------
	localparam int MAIN_AW = 7;
	localparam int EXT_AW = 5;
	localparam int SERIAL_BYTES = 8;
	localparam logic [MAIN_AW-1:0] PTR_RESET = 7'h00;
	localparam int ZONE_MSB = 6;
	localparam int ZONE_LSB = 5;

	// ------------------------------------------------------------------
	// Zone protection register addresses and data values
	// ------------------------------------------------------------------
	localparam logic [3:0] ZONE0_ADDR = 4'h1;
	localparam logic [3:0] ZONE1_ADDR = 4'h2;
	localparam logic [3:0] ZONE2_ADDR = 4'h4;
	localparam logic [3:0] ZONE3_ADDR = 4'h8;
	localparam logic [3:0] ZONE_RESET = 4'h0;
	localparam logic [7:0] ZONE_RD_CLEAR = 8'h00;
	localparam logic [7:0] ZONE_RD_SET = 8'hff;
	localparam logic [7:0] ZONE_SET_DATA = 8'hff;

	// ------------------------------------------------------------------
	// Identification value layout
	// ------------------------------------------------------------------
	localparam int ID_BYTES = 3;
	localparam int ID_MFR_W = 12;
	localparam int ID_DENS_W = 9;
	localparam int ID_REV_W = 3;

	// ------------------------------------------------------------------
	// Serial check byte: x^8+x^5+x^4+1, reflected, LSB first
	// ------------------------------------------------------------------
	localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// ------------------------------------------------------------------
	// Self-timed write cycle (cycles at 20 MHz), default arbitrary
	// ------------------------------------------------------------------
	localparam int WR_CYCLES_DEF = 100000;
	localparam int BUSY_W = 20;

	typedef enum logic [2:0] {
		ST_IDLE, ST_DEV, ST_WADDR, ST_WDATA, ST_READ, ST_IGNORE
	} swe_state_e;

	typedef enum logic [1:0] {
		RG_MAIN, RG_EXT, RG_IDENT, RG_ZONE
	} swe_region_e;

endpackage

/* File: hw/swe_fifo.sv */
// Parameterised valid/ready FIFO for outgoing read bytes
`timescale 1ns/1ps
module swe_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk, // Clock
	input wire logic srst, // Sync reset
	input wire logic inValid, // Write request
	output logic inReady, // Space available
	input wire logic [WIDTH-1:0] inData, // Write data
	output logic outValid, // Data available
	input wire logic outReady, // Read accept
	output logic [WIDTH-1:0] outData // Read data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [CW-1:0] count;
	logic doWr;
	logic doRd;

	assign inReady = (count != CW'(DEPTH));
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];
	assign doWr = inValid && inReady;
	assign doRd = outValid && outReady;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	always_ff @(posedge clk) begin
		if (doWr) begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (doWr) begin
				wrPtr <= bump(wrPtr);
			end
			if (doRd) begin
				rdPtr <= bump(rdPtr);
			end
			if (doWr && !doRd) begin
				count <= CW'(count + 1'b1);
			end else if (doRd && !doWr) begin
				count <= CW'(count - 1'b1);
			end
		end
	end
endmodule

/* File: hw/swe_core.sv */
// Byte-level read, identification and zone-protection logic of the EEPROM
`timescale 1ns/1ps
// Behaviour
// - Each byte loaded advances pointer, except zone reads; master ack sends next byte
// - Main pointer wraps past end to 00h
// - Master nack ends read, back to standby
// - Nibble 1011 selects extended, 1010 main
// - Serial: product byte, 48-bit number, check
// - Check byte is CRC-8 over 56 bits
// - Extended read continues at 08h, wraps 00h
// - Ident opcode: ack read, nack write
// - Ident sends three bytes, MSB first
// - Ack on third ident byte wraps
// - Ident fields: maker, density, revision
// - Four 32-byte zones over main array
// - Zone bits are nonvolatile, survive reset
// - Zone bit 1 blocks writes to zone
// - Zone registers at 01h 02h 04h 08h
// - Zone command sets register to one
// - Zone register never returns to zero
// - Zone read returns 00h or FFh
// - FFh sets zone; busy write cycle after stop
// - Protected write: data nack, ready at once
module swe_core
	import swe_pkg::*;
#(
	parameter int WR_CYCLES = WR_CYCLES_DEF,
	parameter int FIFO_DEPTH = 16,
	parameter logic [7:0] PRODUCT_ID = 8'h5c, // Arbitrary value
	parameter logic [47:0] UNIQUE_NUM = 48'h123456789abc, // Arbitrary value
	parameter logic [ID_MFR_W-1:0] MFR_CODE = 12'h5a5, // Arbitrary value
	parameter logic [ID_DENS_W-1:0] DENS_CODE = 9'h0a5, // Arbitrary value
	parameter logic [ID_REV_W-1:0] REV_CODE = 3'h1, // Arbitrary value
	parameter logic [3:0] ZONE_INIT = ZONE_RESET
) (
	input wire logic clk, // 20 MHz clock
	input wire logic srst, // Sync reset, active high
	input wire logic [2:0] slaveAddr, // Strapped slave address
	input wire logic frameStart, // Start or repeated start pulse
	input wire logic frameStop, // Stop pulse
	input wire logic rxValid, // Byte from master pulse
	input wire logic [7:0] rxByte, // Byte from master
	input wire logic masterAckValid, // Master ack slot pulse
	input wire logic masterNack, // Master answered nack
	output logic ackOutValid, // Device answer pulse
	output logic ackOutNack, // Device answer is nack
	output logic txValid, // Read byte available
	input wire logic txReady, // Read byte taken
	output logic [7:0] txData, // Read byte
	output logic busy // Self-timed write running
);
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [7:0] crc8(input logic [55:0] d);
		logic [7:0] c;
		logic mix;
		c = CRC_INIT;
		for (int i = 0; i < 56; i++) begin
			mix = c[0] ^ d[i];
			c = {1'b0, c[7:1]};
			if (mix) begin
				c = c ^ CRC_POLY_REFL;
			end
		end
		crc8 = c;
	endfunction

	function automatic logic [2:0] zoneDecode(input logic [7:0] a);
		case (a[3:0])
			ZONE0_ADDR: zoneDecode = 3'h4;
			ZONE1_ADDR: zoneDecode = 3'h5;
			ZONE2_ADDR: zoneDecode = 3'h6;
			ZONE3_ADDR: zoneDecode = 3'h7;
			default: zoneDecode = 3'h0;
		endcase
	endfunction

	function automatic logic [MAIN_AW-1:0] nextPtr(
		input logic [MAIN_AW-1:0] p,
		input logic ext
	);
		if (ext) begin
			nextPtr = {2'b00, EXT_AW'(p[EXT_AW-1:0] + 1'b1)};
		end else begin
			nextPtr = MAIN_AW'(p + 1'b1);
		end
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	localparam logic [55:0] SERIAL_BODY = {UNIQUE_NUM, PRODUCT_ID};
	localparam logic [7:0] SERIAL_CRC = crc8(SERIAL_BODY);
	localparam logic [23:0] IDENT_VAL = {MFR_CODE, DENS_CODE, REV_CODE};

	logic [7:0] mainMem [2**MAIN_AW];
	logic [7:0] extMem [2**EXT_AW];
	logic [3:0] zoneProt = ZONE_INIT;
	swe_state_e state;
	swe_region_e region;
	logic [MAIN_AW-1:0] ptr;
	logic [1:0] idIdx;
	logic [1:0] zoneSel;
	logic [2:0] zoneCode;
	logic needPush;
	logic writePend;
	logic zonePend;
	logic [BUSY_W-1:0] busyCnt;

	logic [3:0] opcode;
	logic devMatch;
	logic devAck;
	logic waddrAck;
	logic wdataAck;
	logic respond;
	logic ackNext;
	logic [7:0] readByte;
	logic [EXT_AW-1:0] extIdx;
	logic fifoInReady;
	logic fifoOutValid;
	logic [7:0] fifoOutData;
	logic fifoPop;
	logic doPush;
	logic startWrite;

	// ------------------------------------------------------------------
	// Decode of received bytes
	// ------------------------------------------------------------------
	assign opcode = rxByte[DEV_OP_MSB:DEV_OP_LSB];
	assign devMatch = (rxByte[DEV_SLV_MSB:DEV_SLV_LSB] == slaveAddr);
	assign extIdx = ptr[EXT_AW-1:0];
	assign zoneCode = zoneDecode(rxByte);

	always_comb begin
		devAck = 1'b0;
		if (devMatch) begin
			case (opcode)
				OP_MAIN: devAck = 1'b1;
				OP_EXT: devAck = 1'b1;
				OP_IDENT: devAck = rxByte[DEV_RW_BIT];
				OP_ZONE: devAck = 1'b1;
				default: devAck = 1'b0;
			endcase
		end
	end

	always_comb begin
		case (region)
			RG_ZONE: waddrAck = zoneCode[2];
			default: waddrAck = 1'b1;
		endcase
	end

	always_comb begin
		case (region)
			RG_MAIN: wdataAck = !zoneProt[ptr[ZONE_MSB:ZONE_LSB]];
			RG_EXT: wdataAck = (extIdx >= EXT_AW'(SERIAL_BYTES));
			RG_ZONE: wdataAck = (rxByte == ZONE_SET_DATA);
			default: wdataAck = 1'b0;
		endcase
	end

	always_comb begin
		respond = 1'b0;
		ackNext = 1'b0;
		if (rxValid) begin
			if (busy) begin
				respond = (state != ST_IDLE);
			end else begin
				case (state)
					ST_DEV: begin
						respond = 1'b1;
						ackNext = devAck;
					end
					ST_WADDR: begin
						respond = 1'b1;
						ackNext = waddrAck;
					end
					ST_WDATA: begin
						respond = 1'b1;
						ackNext = wdataAck;
					end
					default: respond = 1'b0;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Read byte selection
	// ------------------------------------------------------------------
	always_comb begin
		case (region)
			RG_MAIN: readByte = mainMem[ptr];
			RG_EXT: begin
				if (extIdx < EXT_AW'(SERIAL_BYTES - 1)) begin
					readByte = SERIAL_BODY[8*extIdx[2:0] +: 8];
				end else if (extIdx == EXT_AW'(SERIAL_BYTES - 1)) begin
					readByte = SERIAL_CRC;
				end else begin
					readByte = extMem[extIdx];
				end
			end
			RG_IDENT: readByte = IDENT_VAL[8*(2-idIdx) +: 8];
			RG_ZONE: begin
				readByte = zoneProt[zoneSel] ? ZONE_RD_SET : ZONE_RD_CLEAR;
			end
			default: readByte = 8'h00;
		endcase
	end

	assign doPush = (state == ST_READ) && needPush && fifoInReady;
	assign startWrite = frameStop && (writePend || zonePend) && !busy;

	// ------------------------------------------------------------------
	// Command sequencer and shared pointer
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= ST_IDLE;
			region <= RG_MAIN;
			ptr <= PTR_RESET;
			idIdx <= '0;
			zoneSel <= '0;
			needPush <= 1'b0;
			writePend <= 1'b0;
			zonePend <= 1'b0;
		end else if (frameStop) begin
			state <= ST_IDLE;
			needPush <= 1'b0;
			writePend <= 1'b0;
			zonePend <= 1'b0;
		end else if (frameStart) begin
			state <= busy ? ST_IDLE : ST_DEV;
			needPush <= 1'b0;
		end else begin
			case (state)
				ST_DEV: begin
					if (rxValid && !busy) begin
						case (opcode)
							OP_EXT: region <= RG_EXT;
							OP_IDENT: region <= RG_IDENT;
							OP_ZONE: region <= RG_ZONE;
							default: region <= RG_MAIN;
						endcase
						idIdx <= '0;
						if (!devAck) begin
							state <= ST_IGNORE;
						end else if (rxByte[DEV_RW_BIT]) begin
							state <= ST_READ;
							needPush <= 1'b1;
						end else begin
							state <= ST_WADDR;
						end
					end
				end
				ST_WADDR: begin
					if (rxValid && !busy) begin
						state <= waddrAck ? ST_WDATA : ST_IGNORE;
						case (region)
							RG_EXT: ptr <= {2'b00, rxByte[EXT_AW-1:0]};
							RG_ZONE: zoneSel <= zoneCode[1:0];
							default: ptr <= rxByte[MAIN_AW-1:0];
						endcase
					end
				end
				ST_WDATA: begin
					if (rxValid && !busy) begin
						if (!wdataAck) begin
							state <= ST_IGNORE;
						end else if (region == RG_ZONE) begin
							zonePend <= 1'b1;
						end else begin
							writePend <= 1'b1;
							ptr <= nextPtr(ptr, region == RG_EXT);
						end
					end
				end
				ST_READ: begin
					if (doPush) begin
						needPush <= 1'b0;
						if (region == RG_IDENT) begin
							idIdx <= (idIdx == 2'(ID_BYTES - 1)) ? '0 : 2'(idIdx + 1'b1);
						end else if (region != RG_ZONE) begin
							ptr <= nextPtr(ptr, region == RG_EXT);
						end
					end else if (masterAckValid) begin
						if (masterNack) begin
							state <= ST_IDLE;
						end else begin
							needPush <= 1'b1;
						end
					end
				end
				ST_IDLE: state <= ST_IDLE;
				ST_IGNORE: state <= ST_IGNORE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Array storage, no reset
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!srst && !busy && rxValid && state == ST_WDATA && wdataAck) begin
			if (region == RG_MAIN) begin
				mainMem[ptr] <= rxByte;
			end else if (region == RG_EXT) begin
				extMem[extIdx] <= rxByte;
			end
		end
	end

	// ------------------------------------------------------------------
	// Zone protection bits, kept over srst
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (startWrite && zonePend) begin
			zoneProt[zoneSel] <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Self-timed write cycle
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			busy <= 1'b0;
			busyCnt <= '0;
		end else if (startWrite) begin
			busy <= 1'b1;
			busyCnt <= BUSY_W'(WR_CYCLES - 1);
		end else if (busy) begin
			if (busyCnt == '0) begin
				busy <= 1'b0;
			end else begin
				busyCnt <= BUSY_W'(busyCnt - 1'b1);
			end
		end
	end

	// ------------------------------------------------------------------
	// Acknowledge answer to master bytes
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			ackOutValid <= 1'b0;
			ackOutNack <= 1'b1;
		end else begin
			ackOutValid <= respond;
			if (respond) begin
				ackOutNack <= !ackNext;
			end
		end
	end

	// ------------------------------------------------------------------
	// Outgoing byte buffer and output stage
	// ------------------------------------------------------------------
	swe_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) txFifo (
		.clk(clk),
		.srst(srst),
		.inValid(doPush),
		.inReady(fifoInReady),
		.inData(readByte),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOutData)
	);

	assign fifoPop = !txValid || txReady;

	always_ff @(posedge clk) begin
		if (srst) begin
			txValid <= 1'b0;
			txData <= 8'h00;
		end else if (fifoPop) begin
			txValid <= fifoOutValid;
			if (fifoOutValid) begin
				txData <= fifoOutData;
			end
		end
	end
endmodule

/* File: tb/swe_master_model.sv */
// Frame-layer model that takes read bytes, promptly or slowly
`timescale 1ns/1ps
module swe_master_model (
	input wire logic clk, // Clock
	input wire logic srst, // Sync reset
	input wire logic slow, // Stall each byte
	input wire logic txValid, // Byte offered
	input wire logic [7:0] txData, // Offered byte
	output logic txReady, // Take strobe
	output logic [7:0] gotData, // Last byte taken
	output logic [7:0] gotCount // Bytes taken
);
	// ------------------------------------------------------------------
	// Stall then take
	// ------------------------------------------------------------------
	logic [1:0] waitCnt;
	assign txReady = !slow || waitCnt == 2'h3;
	always_ff @(posedge clk) begin
		if (srst || !txValid || txReady) begin
			waitCnt <= 2'h0;
		end else begin
			waitCnt <= waitCnt + 2'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			gotCount <= 8'h00;
		end else if (txValid && txReady) begin
			gotCount <= gotCount + 8'h01;
			gotData <= txData;
		end
	end
endmodule

/* File: tb/swe_core_props.sv */
// Port-level checker for the EEPROM read and zone core
`timescale 1ns/1ps
module swe_core_props
	import swe_pkg::*;
#(
	parameter int WR_CYCLES = 10
) (
	input wire logic clk, // Clock
	input wire logic srst, // Sync reset
	input wire logic [2:0] slaveAddr, // Slave address
	input wire logic frameStart, // Start
	input wire logic frameStop, // Stop
	input wire logic rxValid, // Byte in
	input wire logic [7:0] rxByte, // Byte value
	input wire logic masterAckValid, // Ack slot
	input wire logic masterNack, // Master nack
	input wire logic ackOutValid, // Answer
	input wire logic ackOutNack, // Answer nack
	input wire logic txValid, // Byte out
	input wire logic txReady, // Byte taken
	input wire logic [7:0] txData, // Byte value
	input wire logic busy // Write cycle
);
	// ------------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------------
	logic afterStart;
	int busyCnt;
	logic devByte;
	assign devByte = rxValid && afterStart && !busy && !frameStart &&
		!frameStop;
	always_ff @(posedge clk) begin
		if (srst || frameStop || rxValid) begin
			afterStart <= 1'b0;
		end else if (frameStart && !busy) begin
			afterStart <= 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		busyCnt <= (busy && !srst) ? busyCnt + 1 : 0;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_ident_rd_ack: assert property (
		devByte && rxByte[3:1] == slaveAddr && rxByte[7:4] == OP_IDENT &&
		rxByte[0] |=> ackOutValid && !ackOutNack)
		else $error("ident read not acked");
	a_ident_wr_nack: assert property (
		devByte && rxByte[3:1] == slaveAddr && rxByte[7:4] == OP_IDENT &&
		!rxByte[0] |=> ackOutValid && ackOutNack)
		else $error("ident write not nacked");
	a_region_op_ack: assert property (
		devByte && rxByte[3:1] == slaveAddr &&
		(rxByte[7:4] == OP_MAIN || rxByte[7:4] == OP_EXT)
		|=> ackOutValid && !ackOutNack)
		else $error("region opcode not acked");
	a_bad_slave_nack: assert property (
		devByte && rxByte[3:1] != slaveAddr |=> ackOutValid && ackOutNack)
		else $error("foreign slave address acked");
	a_ack_after_byte: assert property (
		ackOutValid |-> $past(rxValid))
		else $error("answer without a byte");
	a_tx_held: assert property (
		txValid && !txReady |=> txValid && $stable(txData))
		else $error("read byte dropped while stalled");
	a_busy_after_stop: assert property (
		$rose(busy) |-> $past(frameStop))
		else $error("write cycle without stop");
	a_busy_length: assert property (
		$fell(busy) |-> busyCnt == WR_CYCLES)
		else $error("write cycle length wrong");
	a_reset_quiet: assert property (
		$fell(srst) |-> !txValid && !ackOutValid && !busy && ackOutNack)
		else $error("outputs active after reset");
	c_write_cycle: cover property ($rose(busy));
	c_byte_taken: cover property (txValid && txReady);
	c_nack_sent: cover property (ackOutValid && ackOutNack);
endmodule
bind swe_core swe_core_props #(.WR_CYCLES(WR_CYCLES)) swe_core_props_i (
	.clk, .srst, .slaveAddr, .frameStart, .frameStop, .rxValid, .rxByte,
	.masterAckValid, .masterNack, .ackOutValid, .ackOutNack, .txValid,
	.txReady, .txData, .busy);

/* File: tb/tb_top.sv */
// Self-checking bench for the EEPROM read and zone core
`timescale 1ns/1ps
module tb_top
	import swe_pkg::*;
;
	// ------------------------------------------------------------------
	// Setup, arbitrary identity values
	// ------------------------------------------------------------------
	localparam logic [2:0] SLV = 3'h5;
	localparam logic [7:0] PID = 8'h6e;
	localparam logic [47:0] UNQ = 48'h0f1e2d3c4b5a;
	localparam logic [23:0] IDV = {12'h3c1, 9'h12b, 3'h6};
	logic clk = 0, srst = 1, frameStart = 0, frameStop = 0, slow = 0;
	logic rxValid = 0, masterAckValid = 0, masterNack = 0;
	logic [7:0] rxByte = 8'h00;
	logic [2:0] slaveAddr = SLV;
	logic ackOutValid, ackOutNack, txValid, txReady, busy;
	logic [7:0] txData, gotData, gotCount;
	logic [7:0] sn [8];
	int badCount = 0, checkCount = 0;
	always #25 clk = ~clk;
	swe_core #(.WR_CYCLES(10), .PRODUCT_ID(PID), .UNIQUE_NUM(UNQ),
		.MFR_CODE(IDV[23:12]), .DENS_CODE(IDV[11:3]), .REV_CODE(IDV[2:0])
	) swe_core_i (.clk, .srst, .slaveAddr, .frameStart, .frameStop,
		.rxValid, .rxByte, .masterAckValid, .masterNack, .ackOutValid,
		.ackOutNack, .txValid, .txReady, .txData, .busy);
	swe_master_model swe_master_model_i (.clk, .srst, .slow, .txValid,
		.txData, .txReady, .gotData, .gotCount);
	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp) begin
			badCount++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic completeRun();
		$display("checks %0d mismatches %0d", checkCount, badCount);
		if (badCount == 0 && checkCount > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic frame(input logic stop);
		@(posedge clk);
		frameStart <= !stop;
		frameStop <= stop;
		@(posedge clk);
		frameStart <= 1'b0;
		frameStop <= 1'b0;
	endtask
	task automatic send(input logic [7:0] b, input logic nack);
		@(posedge clk);
		rxValid <= 1'b1;
		rxByte <= b;
		@(posedge clk);
		rxValid <= 1'b0;
		#1;
		check({7'h00, ackOutValid}, 8'h01);
		check({7'h00, ackOutNack}, {7'h00, nack});
	endtask
	task automatic setPtr(input logic [3:0] op, input logic [7:0] a);
		frame(0);
		send({op, SLV, 1'b0}, 0);
		send(a, 0);
	endtask
	task automatic rd(input logic [3:0] op);
		frame(0);
		send({op, SLV, 1'b1}, 0);
	endtask
	task automatic get(input logic [7:0] exp, input logic nack);
		int n;
		logic [7:0] c0;
		c0 = gotCount;
		n = 0;
		while (gotCount === c0 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 200) begin
			badCount++;
			completeRun();
		end else begin
			check(gotData, exp);
			@(posedge clk);
			masterAckValid <= 1'b1;
			masterNack <= nack;
			@(posedge clk);
			masterAckValid <= 1'b0;
		end
	endtask
	task automatic waitIdle();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (busy !== 1'b0 && n < 100);
		if (n >= 100) begin
			badCount++;
			completeRun();
		end
	endtask
	task automatic zones(input logic [3:0] exp);
		for (int z = 0; z < 4; z++) begin
			setPtr(OP_ZONE, 8'h01 << z);
			rd(OP_ZONE);
			get(exp[z] ? 8'hff : 8'h00, 1);
		end
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		sn[0] = PID;
		for (int i = 1; i < 7; i++) sn[i] = UNQ[8*i-8 +: 8];
		sn[7] = CRC_INIT;
		for (int i = 0; i < 56; i++) begin
			sn[7] = (sn[7] >> 1) ^ ((sn[7][0] ^ sn[i/8][i%8]) ?
				CRC_POLY_REFL : 8'h00);
		end
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		zones(4'h0);
		setPtr(OP_ZONE, 8'h02);
		send(ZONE_SET_DATA, 0);
		frame(1);
		#1;
		check({7'h00, busy}, 8'h01);
		waitIdle();
		setPtr(OP_ZONE, 8'h04);
		send(8'h5a, 1);
		frame(0);
		send({OP_ZONE, SLV, 1'b0}, 0);
		send(8'h03, 1);
		frame(1);
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		zones(4'h2);
		frame(0);
		send({OP_IDENT, SLV, 1'b0}, 1);
		frame(0);
		send({OP_MAIN, 3'h2, 1'b1}, 1);
		frame(1);
		setPtr(OP_MAIN, 8'h20);
		send(8'h99, 1);
		setPtr(OP_MAIN, 8'h7f);
		send(8'h11, 0);
		send(8'h22, 0);
		frame(1);
		waitIdle();
		setPtr(OP_MAIN, 8'h3f);
		send(8'h44, 1);
		setPtr(OP_MAIN, 8'h1f);
		send(8'h33, 0);
		frame(1);
		waitIdle();
		setPtr(OP_MAIN, 8'h7f);
		rd(OP_MAIN);
		get(8'h11, 0);
		get(8'h22, 1);
		setPtr(OP_MAIN, 8'h1f);
		rd(OP_MAIN);
		get(8'h33, 1);
		setPtr(OP_EXT, 8'h03);
		send(8'h00, 1);
		setPtr(OP_EXT, 8'h08);
		send(8'h3c, 0);
		frame(1);
		waitIdle();
		@(posedge clk);
		slow <= 1'b1;
		setPtr(OP_EXT, 8'h00);
		rd(OP_EXT);
		for (int i = 0; i < 8; i++) get(sn[i], 0);
		get(8'h3c, 1);
		slow <= 1'b0;
		rd(OP_IDENT);
		for (int i = 0; i < 4; i++) get(IDV[8*(2-i%3) +: 8], i == 3);
		completeRun();
	end
endmodule
